// >>> logic/dgbl_loader.sv
// Drive geometry block loader: walks parameter blocks in host memory,
// checks them and holds the derived geometry of up to two physical drives.
// Assumes an APB master on the register side and a req/ack memory port.
//
// Functional notes
// - A block is sixteen consecutive words, read in fixed order from unit count.
// - First block sets drive 0; two units copy it, else next block sets drive 1.
// - Unit count at most 2; zero means the rest is disregarded.
// - Drive type word must be exactly one.
// - Head offset 0..31, used by head splits, zero for splits 0 and 1.
// - Logical sectors per track 1..255, spares excluded.
// - Data heads per drive 1..63.
// - Logical cylinders 1..4095, alternates excluded.
// - Spare sectors 0 or 1; physical sectors are logical plus spares.
// - Alternates 0..15; physical cylinders are logical plus alternates.
// - Block replacement needs an alternate; with it on, spares reserve a working track.
// - Cylinder split halves the alternates; replacement then needs at least two.
// - Feature word 0..7; bit 0 means on-cylinder drops during head select.
// - Feature bit 1 means early and late strobe capable.
// - Feature bit 2 means head offset capable.
// - Split 0 keeps one unit; split 1 splits cylinders at the cylinder offset.
// - Split 2 splits heads at the starting head offset.
// - Split 3 splits heads with low heads as logical drive 1.
// - Removable flag is one bit unsplit, two bits (one per unit) when split.
// - Cylinder offset used only for split 1, zero otherwise.
// - Spiral offset 0..15 sectors of skew per track.
`timescale 1ns/100ps
`default_nettype none
module dgbl_loader (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // Host memory
  output logic                  mem_req,
  output logic [15:0]           mem_addr,
  input  wire logic             mem_ack,
  input  wire logic [15:0]      mem_rdata,
  // Geometry for address translation
  output logic                  cfg_valid,
  output logic [1:0][8:0]       phys_spt,
  output logic [1:0][12:0]      phys_cyl,
  output logic [1:0][5:0]       heads
);

  typedef struct packed {
    dgbl_pkg::dgbl_state_t   st;
    logic [3:0]              widx;
    logic [15:0][15:0]       blk;
    logic [15:0]             addr;
    logic [1:0]              ndrv;
    logic                    busy;
    logic                    done;
    logic                    err;
    logic [4:0]              err_code;
    logic                    valid;
    logic                    repl_en;
    logic [15:0]             base;
    logic                    rd_go;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    dgbl_pkg::dgbl_drv_t [1:0] drv;
  } dgbl_top_state_t;

  dgbl_top_state_t q;
  dgbl_top_state_t next_q;

  logic        rd_valid;
  logic [15:0] rd_data;
  logic        blk_bad;
  logic [4:0]  blk_bad_word;

  dgbl_rd u_rd (
    .pclk      (pclk),
    .presetn   (presetn),
    .go        (q.rd_go),
    .go_addr   (q.addr),
    .rd_valid  (rd_valid),
    .rd_data   (rd_data),
    .mem_req   (mem_req),
    .mem_addr  (mem_addr),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  dgbl_chk u_chk (
    .blk      (q.blk),
    .repl_en  (q.repl_en),
    .bad      (blk_bad),
    .bad_word (blk_bad_word)
  );

  // Derive the held geometry of one accepted block
  function automatic dgbl_pkg::dgbl_drv_t make_drv(input logic [15:0][15:0] b,
                                                   input logic repl);
    dgbl_pkg::dgbl_drv_t d;
    logic [1:0]          sp;
    sp = b[dgbl_pkg::W_SPLIT][1:0];
    d.phys_spt = 9'(b[dgbl_pkg::W_SPT]) + 9'(b[dgbl_pkg::W_SPARE]);
    d.heads = b[dgbl_pkg::W_HEADS][5:0];
    d.phys_cyl = 13'(b[dgbl_pkg::W_CYL]) + 13'(b[dgbl_pkg::W_ALT]);
    // Each logical unit of a cylinder split gets half of the alternates
    d.alt_unit = (sp == 2'(dgbl_pkg::SPLIT_CYL)) ? (b[dgbl_pkg::W_ALT][3:0] >> 1)
                 : b[dgbl_pkg::W_ALT][3:0];
    d.work_trk = repl && b[dgbl_pkg::W_SPARE][0];
    d.split = dgbl_pkg::dgbl_split_t'(sp);
    d.oncyl_drop = b[dgbl_pkg::W_FEAT][0];
    d.strobe_cap = b[dgbl_pkg::W_FEAT][1];
    d.offset_cap = b[dgbl_pkg::W_FEAT][2];
    // Unsplit drives have a single flag; the unit 1 bit is forced clear
    d.removable = (sp == 2'(dgbl_pkg::SPLIT_NONE)) ? {1'b0, b[dgbl_pkg::W_REM][0]}
                  : b[dgbl_pkg::W_REM][1:0];
    d.head_ofs = b[dgbl_pkg::W_HOFS][4:0];
    d.spiral = b[dgbl_pkg::W_SPIRAL][3:0];
    d.cyl_ofs = b[dgbl_pkg::W_COFS];
    make_drv = d;
  endfunction

  // One drive register, selected by the low address bits
  function automatic logic [31:0] drv_word(input dgbl_pkg::dgbl_drv_t d,
                                           input logic [1:0] sel);
    logic [31:0] w;
    w = '0;
    unique case (sel)
      dgbl_pkg::DRV_SIZE: w = {10'h000, d.heads, 7'h00, d.phys_spt};
      dgbl_pkg::DRV_CYLS: w = {12'h000, d.alt_unit, 3'h0, d.phys_cyl};
      dgbl_pkg::DRV_MODE: w = {11'h000, d.work_trk, d.spiral, 3'h0, d.head_ofs,
                               1'b0, d.removable, d.offset_cap, d.strobe_cap,
                               d.oncyl_drop, d.split};
      dgbl_pkg::DRV_COFS: w = {16'h0000, d.cyl_ofs};
    endcase
    drv_word = w;
  endfunction

  logic        acc;
  logic        wr_end;
  logic        start_req;
  logic        drv_hit;
  logic        drv_sel;
  logic [15:0] step_addr;
  logic        at_top;

  assign acc       = psel && penable && !q.pready;
  assign wr_end    = psel && penable && pwrite && q.pready;
  assign drv_hit   = (paddr[11:4] == dgbl_pkg::DRV_REGION0)
                     || (paddr[11:4] == dgbl_pkg::DRV_REGION1);
  assign drv_sel   = (paddr[11:4] == dgbl_pkg::DRV_REGION1);
  assign step_addr = q.addr + dgbl_pkg::WORD_STEP;
  // Walking past the top of the 64K window would wrap to address zero
  assign at_top    = (q.addr == dgbl_pkg::ADDR_LAST);

  always_comb
  begin
    next_q = q;
    next_q.rd_go = 1'b0;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    start_req = 1'b0;

    // APB: one wait state, answer registered
    if (acc)
    begin
      next_q.pready = 1'b1;
      next_q.prdata = '0;
      if (paddr == dgbl_pkg::REG_CTRL)
      begin
        if (!pwrite)
          next_q.prdata[dgbl_pkg::CTRL_REPL] = q.repl_en;
      end
      else if (paddr == dgbl_pkg::REG_BASE)
      begin
        if (!pwrite)
          next_q.prdata = {16'h0000, q.base};
      end
      else if (paddr == dgbl_pkg::REG_STATUS)
      begin
        if (!pwrite)
        begin
          next_q.prdata[dgbl_pkg::STS_BUSY] = q.busy;
          next_q.prdata[dgbl_pkg::STS_DONE] = q.done;
          next_q.prdata[dgbl_pkg::STS_ERR] = q.err;
          next_q.prdata[dgbl_pkg::STS_VALID] = q.valid;
          next_q.prdata[12:8] = q.err_code;
          next_q.prdata[17:16] = q.ndrv;
        end
      end
      else if (drv_hit)
      begin
        if (!pwrite)
          next_q.prdata = drv_word(q.drv[drv_sel], paddr[3:2]);
      end
      else
        next_q.pslverr = 1'b1;
    end

    // Writes land only at the edge where the master sees pready
    if (wr_end && (paddr == dgbl_pkg::REG_CTRL))
    begin
      start_req = pwdata[dgbl_pkg::CTRL_START];
      // Option is frozen during a load so one load sees one setting
      if (!q.busy)
        next_q.repl_en = pwdata[dgbl_pkg::CTRL_REPL];
    end
    if (wr_end && (paddr == dgbl_pkg::REG_BASE))
      next_q.base = pwdata[15:0];

    unique case (q.st)
      dgbl_pkg::ST_IDLE:
      begin
        if (start_req)
        begin
          next_q.done = 1'b0;
          next_q.err = 1'b0;
          next_q.err_code = dgbl_pkg::ERR_NONE;
          next_q.valid = 1'b0;
          next_q.ndrv = 2'h0;
          next_q.widx = dgbl_pkg::W_UNITS;
          next_q.addr = q.base;
          if (q.base[0])
          begin
            next_q.done = 1'b1;
            next_q.err = 1'b1;
            next_q.err_code = dgbl_pkg::ERR_ADDR;
          end
          else
          begin
            next_q.busy = 1'b1;
            next_q.st = dgbl_pkg::ST_READ;
          end
        end
      end
      dgbl_pkg::ST_READ:
      begin
        next_q.rd_go = 1'b1;
        next_q.st = dgbl_pkg::ST_WAIT;
      end
      dgbl_pkg::ST_WAIT:
      begin
        if (rd_valid)
        begin
          next_q.blk[q.widx] = rd_data;
          if ((q.widx == dgbl_pkg::W_UNITS) && (rd_data == dgbl_pkg::ZERO_WORD))
          begin
            // A zero unit count where a block would start ends the walk
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
            next_q.valid = (q.ndrv != 2'h0);
            next_q.st = dgbl_pkg::ST_IDLE;
          end
          else if ((q.widx == dgbl_pkg::W_UNITS) && (q.ndrv == 2'h2))
          begin
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
            next_q.err = 1'b1;
            next_q.err_code = dgbl_pkg::ERR_EXTRA;
            next_q.st = dgbl_pkg::ST_IDLE;
          end
          else if (q.widx == dgbl_pkg::W_LAST)
            next_q.st = dgbl_pkg::ST_EVAL;
          else if (at_top)
          begin
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
            next_q.err = 1'b1;
            next_q.err_code = dgbl_pkg::ERR_ADDR;
            next_q.st = dgbl_pkg::ST_IDLE;
          end
          else
          begin
            next_q.widx = q.widx + 4'h1;
            next_q.addr = step_addr;
            next_q.st = dgbl_pkg::ST_READ;
          end
        end
      end
      dgbl_pkg::ST_EVAL:
      begin
        if (blk_bad || at_top
            || ((q.ndrv == 2'h1) && (q.blk[dgbl_pkg::W_UNITS] == dgbl_pkg::MAX_UNITS)))
        begin
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
          next_q.err = 1'b1;
          next_q.err_code = blk_bad ? blk_bad_word
                            : (at_top ? dgbl_pkg::ERR_ADDR : dgbl_pkg::ERR_EXTRA);
          next_q.st = dgbl_pkg::ST_IDLE;
        end
        else
        begin
          // Lowest block takes drive 0; a two-unit block fills both drives
          next_q.drv[q.ndrv[0]] = make_drv(q.blk, q.repl_en);
          if (q.blk[dgbl_pkg::W_UNITS] == dgbl_pkg::MAX_UNITS)
          begin
            next_q.drv[1] = make_drv(q.blk, q.repl_en);
            next_q.ndrv = 2'h2;
          end
          else
            next_q.ndrv = q.ndrv + 2'h1;
          next_q.widx = dgbl_pkg::W_UNITS;
          next_q.addr = step_addr;
          next_q.st = dgbl_pkg::ST_READ;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= next_q;
  end

  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign prdata    = q.prdata;
  assign cfg_valid = q.valid;

  // Translation geometry straight from the held drive records
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_geom
      assign phys_spt[g] = q.drv[g].phys_spt;
      assign phys_cyl[g] = q.drv[g].phys_cyl;
      assign heads[g]    = q.drv[g].heads;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> logic/dgbl_pkg.sv
// Package for the drive geometry block loader: word layout, limits,
// error codes, register map and shared types.
// Assumes 16-bit host memory words at even byte addresses and a 32-bit APB.
package dgbl_pkg;

  // Block layout (index of each word inside a block)
  localparam logic [3:0]  W_UNITS        = 4'h0;
  localparam logic [3:0]  W_TYPE         = 4'h1;
  localparam logic [3:0]  W_HOFS         = 4'h2;
  localparam logic [3:0]  W_SPT          = 4'h3;
  localparam logic [3:0]  W_HEADS        = 4'h4;
  localparam logic [3:0]  W_CYL          = 4'h5;
  localparam logic [3:0]  W_SPARE        = 4'h6;
  localparam logic [3:0]  W_ALT          = 4'h7;
  localparam logic [3:0]  W_FEAT         = 4'h8;
  localparam logic [3:0]  W_SPLIT        = 4'h9;
  localparam logic [3:0]  W_REM          = 4'ha;
  localparam logic [3:0]  W_COFS         = 4'he;
  localparam logic [3:0]  W_SPIRAL       = 4'hf;
  localparam logic [3:0]  W_LAST         = 4'hf;

  // Field limits
  localparam logic [15:0] MAX_UNITS      = 16'h0002;
  localparam logic [15:0] TYPE_OK        = 16'h0001;
  localparam logic [15:0] MAX_HOFS       = 16'h001f;
  localparam logic [15:0] MAX_SPT        = 16'h00ff;
  localparam logic [15:0] MAX_HEADS      = 16'h003f;
  localparam logic [15:0] MAX_CYL        = 16'h0fff;
  localparam logic [15:0] MAX_SPARE      = 16'h0001;
  localparam logic [15:0] MAX_ALT        = 16'h000f;
  localparam logic [15:0] MAX_FEAT       = 16'h0007;
  localparam logic [15:0] MAX_SPLIT      = 16'h0003;
  localparam logic [15:0] MAX_REM_ONE    = 16'h0001;
  localparam logic [15:0] MAX_REM_TWO    = 16'h0003;
  localparam logic [15:0] MAX_SPIRAL     = 16'h000f;
  localparam logic [15:0] MIN_ONE        = 16'h0001;
  localparam logic [15:0] MIN_ALT_CSPLIT = 16'h0002;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;

  // Memory walk
  localparam logic [15:0] WORD_STEP      = 16'h0002;
  localparam logic [15:0] ADDR_LAST      = 16'hfffe;

  // Error codes: 0 is no error, 1..16 name the failing word, the rest are loader faults
  localparam logic [4:0]  ERR_NONE       = 5'h00;
  localparam logic [4:0]  ERR_EXTRA      = 5'h11;
  localparam logic [4:0]  ERR_ADDR       = 5'h12;

  // Register map (byte addresses)
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_BASE       = 12'h004;
  localparam logic [11:0] REG_STATUS     = 12'h008;
  localparam logic [7:0]  DRV_REGION0    = 8'h01;
  localparam logic [7:0]  DRV_REGION1    = 8'h02;
  localparam logic [1:0]  DRV_SIZE       = 2'h0;
  localparam logic [1:0]  DRV_CYLS       = 2'h1;
  localparam logic [1:0]  DRV_MODE       = 2'h2;
  localparam logic [1:0]  DRV_COFS       = 2'h3;

  // Control and status bit positions
  localparam int          CTRL_START     = 0;
  localparam int          CTRL_REPL      = 1;
  localparam int          STS_BUSY       = 0;
  localparam int          STS_DONE       = 1;
  localparam int          STS_ERR        = 2;
  localparam int          STS_VALID      = 3;

  typedef enum logic [1:0] {
    SPLIT_NONE     = 2'h0,
    SPLIT_CYL      = 2'h1,
    SPLIT_HEAD     = 2'h2,
    SPLIT_HEAD_REV = 2'h3
  } dgbl_split_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WAIT = 2'b11,
    ST_EVAL = 2'b10
  } dgbl_state_t;

  // Accepted geometry of one physical drive
  typedef struct packed {
    logic [8:0]  phys_spt;
    logic [5:0]  heads;
    logic [12:0] phys_cyl;
    logic [3:0]  alt_unit;
    logic        work_trk;
    dgbl_split_t split;
    logic        oncyl_drop;
    logic        strobe_cap;
    logic        offset_cap;
    logic [1:0]  removable;
    logic [4:0]  head_ofs;
    logic [3:0]  spiral;
    logic [15:0] cyl_ofs;
  } dgbl_drv_t;

endpackage

// >>> logic/dgbl_rd.sv
// Single-word reader toward host memory.
// Assumes a req/ack memory port: data is valid with ack, req is held until ack.
`timescale 1ns/100ps
`default_nettype none
module dgbl_rd (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Command from the loader
  input  wire logic        go,
  input  wire logic [15:0] go_addr,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  // Host memory
  output logic             mem_req,
  output logic [15:0]      mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic        valid;
    logic [15:0] data;
  } dgbl_rd_state_t;

  dgbl_rd_state_t q;
  dgbl_rd_state_t next_q;

  always_comb
  begin
    next_q = q;
    next_q.valid = 1'b0;
    if (q.req && mem_ack)
    begin
      next_q.req = 1'b0;
      next_q.valid = 1'b1;
      next_q.data = mem_rdata;
    end
    else if (go && !q.req)
    begin
      next_q.req = 1'b1;
      next_q.addr = go_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= next_q;
  end

  assign mem_req  = q.req;
  assign mem_addr = q.addr;
  assign rd_valid = q.valid;
  assign rd_data  = q.data;

endmodule
`default_nettype wire

// >>> logic/dgbl_chk.sv
// Range and consistency check of one captured sixteen-word block.
// Purely combinational; the caller holds the block stable while it looks.
`timescale 1ns/100ps
`default_nettype none
module dgbl_chk (
  // Captured block and options
  input  wire logic [15:0][15:0] blk,
  input  wire logic              repl_en,
  // Verdict
  output logic                   bad,
  output logic [4:0]             bad_word
);

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic [15:0] fail;
  logic [15:0] split;
  logic [15:0] alt;
  logic        csplit;

  assign split  = blk[dgbl_pkg::W_SPLIT];
  assign alt    = blk[dgbl_pkg::W_ALT];
  assign csplit = (split == 16'(dgbl_pkg::SPLIT_CYL));

  always_comb
  begin
    fail = '0;
    fail[dgbl_pkg::W_UNITS] = !in_range(blk[dgbl_pkg::W_UNITS], dgbl_pkg::MIN_ONE,
                                        dgbl_pkg::MAX_UNITS);
    fail[dgbl_pkg::W_TYPE] = (blk[dgbl_pkg::W_TYPE] != dgbl_pkg::TYPE_OK);
    // Head offset only means something for head splits
    fail[dgbl_pkg::W_HOFS] = !in_range(blk[dgbl_pkg::W_HOFS], dgbl_pkg::ZERO_WORD,
                                       dgbl_pkg::MAX_HOFS)
                             || ((split < 16'(dgbl_pkg::SPLIT_HEAD))
                                 && (blk[dgbl_pkg::W_HOFS] != dgbl_pkg::ZERO_WORD));
    fail[dgbl_pkg::W_SPT] = !in_range(blk[dgbl_pkg::W_SPT], dgbl_pkg::MIN_ONE,
                                      dgbl_pkg::MAX_SPT);
    fail[dgbl_pkg::W_HEADS] = !in_range(blk[dgbl_pkg::W_HEADS], dgbl_pkg::MIN_ONE,
                                        dgbl_pkg::MAX_HEADS);
    fail[dgbl_pkg::W_CYL] = !in_range(blk[dgbl_pkg::W_CYL], dgbl_pkg::MIN_ONE,
                                      dgbl_pkg::MAX_CYL);
    fail[dgbl_pkg::W_SPARE] = !in_range(blk[dgbl_pkg::W_SPARE], dgbl_pkg::ZERO_WORD,
                                        dgbl_pkg::MAX_SPARE);
    // Replacement needs alternates; a cylinder split shares them in equal halves
    fail[dgbl_pkg::W_ALT] = !in_range(alt, dgbl_pkg::ZERO_WORD, dgbl_pkg::MAX_ALT)
                            || (repl_en && (alt < dgbl_pkg::MIN_ONE))
                            || (csplit && alt[0])
                            || (repl_en && csplit && (alt < dgbl_pkg::MIN_ALT_CSPLIT));
    fail[dgbl_pkg::W_FEAT] = !in_range(blk[dgbl_pkg::W_FEAT], dgbl_pkg::ZERO_WORD,
                                       dgbl_pkg::MAX_FEAT);
    fail[dgbl_pkg::W_SPLIT] = !in_range(split, dgbl_pkg::ZERO_WORD, dgbl_pkg::MAX_SPLIT);
    fail[dgbl_pkg::W_REM] = !in_range(blk[dgbl_pkg::W_REM], dgbl_pkg::ZERO_WORD,
                                      (split == 16'(dgbl_pkg::SPLIT_NONE))
                                      ? dgbl_pkg::MAX_REM_ONE : dgbl_pkg::MAX_REM_TWO);
    // Second unit must start inside the logical cylinder range
    fail[dgbl_pkg::W_COFS] = csplit ? (blk[dgbl_pkg::W_COFS] >= blk[dgbl_pkg::W_CYL])
                             : (blk[dgbl_pkg::W_COFS] != dgbl_pkg::ZERO_WORD);
    fail[dgbl_pkg::W_SPIRAL] = !in_range(blk[dgbl_pkg::W_SPIRAL], dgbl_pkg::ZERO_WORD,
                                         dgbl_pkg::MAX_SPIRAL);
  end

  // Report the lowest failing word
  always_comb
  begin
    bad = |fail;
    bad_word = dgbl_pkg::ERR_NONE;
    for (int i = 15; i >= 0; i--)
    begin
      if (fail[i])
        bad_word = 5'(i + 1);
    end
  end

endmodule
`default_nettype wire

// >>> verif/dgbl_loader_chk.sv
// Port assertions for the geometry loader.
// Bound onto dgbl_loader; all on pclk.
`timescale 1ns/100ps
`default_nettype none
module dgbl_loader_chk (
  // APB side
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  // Memory side and geometry
  input wire logic             mem_req,
  input wire logic [15:0]      mem_addr,
  input wire logic             mem_ack,
  input wire logic [15:0]      mem_rdata,
  input wire logic             cfg_valid,
  input wire logic [1:0][8:0]  phys_spt,
  input wire logic [1:0][5:0]  heads
);
  logic zack;
  assign zack = mem_req & mem_ack & (mem_rdata == 16'h0000);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_gap; mem_req && mem_ack |=> !mem_req ##1 !mem_req; endproperty
  a_gap: assert property (p_gap) else $error("request too soon");
  property p_even; mem_req |-> !mem_addr[0]; endproperty
  a_even: assert property (p_even) else $error("odd address");
  property p_geo; cfg_valid |-> phys_spt[0] != 9'h000 && heads[0] != 6'h00; endproperty
  a_geo: assert property (p_geo) else $error("empty geometry");
  property p_end; $rose(cfg_valid) |-> $past(zack) || $past(zack, 2); endproperty
  a_end: assert property (p_end) else $error("valid without end word");
endmodule
bind dgbl_loader dgbl_loader_chk u_dgbl_loader_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .cfg_valid(cfg_valid), .phys_spt(phys_spt), .heads(heads));
`default_nettype wire

// >>> verif/dgbl_host_mem.sv
// Host memory model: one word per request, prompt or slow.
// The bench fills mem, end word and gap words included.
`timescale 1ns/100ps
`default_nettype none
module dgbl_host_mem (
  // Clock, reset, pacing
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  // Memory port
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [32768];
  logic        wt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {mem_ack, wt, mem_rdata} <= 18'h0;
    else if (mem_req && !mem_ack && (wt || !slow))
      {mem_ack, wt, mem_rdata} <= {2'h2, mem[mem_addr[15:1]]};
    else
      // Idle data toggles so a stale word never passes for a fresh one
      {mem_ack, wt, mem_rdata} <= {1'b0, mem_req && !mem_ack, ~mem_rdata};
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Bench for the geometry loader: APB master tasks, host memory model.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic             mem_req, mem_ack, cfg_valid, slow;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, r;
  logic [15:0]      mem_addr, mem_rdata;
  logic [1:0][8:0]  phys_spt;
  logic [1:0][12:0] phys_cyl;
  logic [1:0][5:0]  heads;
  logic [15:0]      blk [16];
  int               errors, tests_run;
  localparam logic [15:0] GOOD [16] = '{16'h1, 16'h1, 16'h0, 16'h11, 16'h5, 16'h64, 16'h1,
    16'h2, 16'h5, 16'h0, 16'h1, 16'h9, 16'h9, 16'h9, 16'h0, 16'h4};
  // Faulty word: index, value
  localparam logic [19:0] BAD [14] = '{20'h00003, 20'h10002, 20'h20001, 20'h30000,
    20'h40040, 20'h51000, 20'h60002, 20'h70010, 20'h80008, 20'h90004, 20'ha0002,
    20'he0001, 20'hf0010, 20'h70000};
  dgbl_loader u_dgbl_loader (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cfg_valid(cfg_valid), .phys_spt(phys_spt),
    .phys_cyl(phys_cyl), .heads(heads));
  dgbl_host_mem u_dgbl_host_mem (.pclk(pclk), .presetn(presetn), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d of %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang;
    errors++;
    finish_test;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 9);
    if (pready !== 1'b1) hang;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic put(input int at);
    for (int k = 0; k < 16; k++)
      u_dgbl_host_mem.mem[at + k] = blk[k];
  endtask
  task automatic load(input logic [31:0] ctl);
    apb(1'b1, 12'h004, 32'h200);
    apb(1'b1, 12'h000, ctl);
    for (int i = 0; i < 400 && r[1] !== 1'b1; i++)
      apb(1'b0, 12'h008, 32'h0);
    if (r[1] !== 1'b1) hang;
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h008, 32'h0);
    chk("status", r, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", {r[30:0], e}, 32'h1);
  endtask
  task automatic t_pair;
    slow <= 1'b1;
    blk = GOOD;
    put(256);
    blk = '{16'h1, 16'h1, 16'h0, 16'hff, 16'h3f, 16'hfff, 16'h0, 16'hf, 16'h0, 16'h0,
      16'h0, 16'h9, 16'h9, 16'h9, 16'h0, 16'hf};
    put(272);
    u_dgbl_host_mem.mem[288] = 16'h0;
    load(32'h1);
    chk("pair sts", r, 32'h2000a);
    chk("spt", phys_spt, {9'hff, 9'h12});
    chk("cyl", phys_cyl, {13'h100e, 13'h66});
    chk("heads", heads, {6'h3f, 6'h05});
    slow <= 1'b0;
  endtask
  task automatic t_units;
    blk = GOOD;
    blk[0] = 16'h2;
    put(256);
    u_dgbl_host_mem.mem[272] = 16'h0;
    load(32'h1);
    chk("twin sts", r, 32'h2000a);
    chk("twin spt", phys_spt, {9'h12, 9'h12});
    u_dgbl_host_mem.mem[256] = 16'h0;
    load(32'h1);
    chk("empty sts", r, 32'h2);
    chk("empty valid", cfg_valid, 32'h0);
  endtask
  task automatic t_split;
    for (int s = 0; s < 4; s++)
    begin
      blk = GOOD;
      blk[9] = 16'(s);
      blk[10] = 16'h3;
      blk[2] = (s > 1) ? 16'h2 : 16'h0;
      blk[14] = (s == 1) ? 16'h32 : 16'h0;
      put(256);
      load(32'h1);
      chk("split sts", r, (s == 0) ? 32'h0b06 : 32'h1000a);
      if (s > 0)
      begin
        apb(1'b0, 12'h018, 32'h0);
        chk("mode", r, {16'h20, 5'(blk[2]), 3'h3, 3'h5, 2'(s)});
        apb(1'b0, 12'h01c, 32'h0);
        chk("cyl ofs", r, 32'(blk[14]));
      end
    end
  endtask
  task automatic t_bad;
    for (int i = 0; i < 14; i++)
    begin
      blk = GOOD;
      blk[BAD[i][19:16]] = BAD[i][15:0];
      put(256);
      load((i == 13) ? 32'h3 : 32'h1);
      chk("bad sts", r, {19'h0, 5'(BAD[i][19:16]) + 5'h1, 8'h06});
      chk("bad valid", cfg_valid, 32'h0);
    end
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, slow} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_pair;
    t_units;
    t_split;
    t_bad;
    finish_test;
  end
endmodule
`default_nettype wire
